// File: rtl/rta_params.svh
// Notes on behaviour
// - Read-only leap year bit at bit 0
// - Bit 1 of enable gates tick interrupt
// - Bit 0 of enable gates alarm interrupt
// - Enabled tick sets status bit 1 periodically
// - Enabled alarm match sets status bit 0
// - Flags stay set until written one
// - Wake enable wakes processor on tick/alarm
// - Tick period is one second over 2^sel
// - Flags read 0 idle, 1 when generated
// - Alarm BCD digits taken without validity check
`ifndef RTA_PARAMS_SVH
`define RTA_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RTA_ADDR_W 12
`define RTA_OFF_LEAP 12'h024
`define RTA_OFF_IRQ_EN 12'h028
`define RTA_OFF_STATUS 12'h02c
`define RTA_OFF_TICK_CFG 12'h030

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTA_BIT_LEAP 0
`define RTA_BIT_MATCH 0
`define RTA_BIT_PERIODIC 1
`define RTA_BIT_WAKE_EN 3
`define RTA_SEL_MSB 2
`define RTA_SEL_LSB 0

// ----------------------------------------
// Reset values and timebase
// ----------------------------------------
`define RTA_RST_IRQ_EN 2'h0
`define RTA_RST_STATUS 2'h0
`define RTA_RST_SEL 3'h0
`define RTA_BASE_LOG2 7

`endif

// File: rtl/rta_pkg.sv
package rta_pkg;
  typedef struct packed {
    logic base_s1;
    logic base_s2;
    logic base_s3;
    logic match_s1;
    logic match_s2;
    logic match_s3;
    logic leap_s1;
    logic leap_s2;
    logic pd_s1;
    logic pd_s2;
    logic [6:0] cnt;
    logic [1:0] irq_en;
    logic [1:0] status;
    logic [2:0] period_select;
    logic wake_from_powerdown_enable;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic wake_req;
  } rta_state_t;
endpackage

// File: rtl/rta_tick_alarm.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rta_params.svh"

module rta_tick_alarm
  import rta_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic base_clk_pin,
  input wire logic alarm_match_pin,
  input wire logic leap_year_flag,
  input wire logic powerdown_pin,
  output logic irq,
  output logic wake_req
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  rta_state_t q;
  rta_state_t next_q;
  logic base_edge;
  logic tick_evt;
  logic match_evt;
  logic [6:0] next_cnt;
  logic [6:0] mask;
  logic access;
  logic wr_done;
  logic hit;
  logic [31:0] rd_val;
  logic [1:0] clr;
  logic [1:0] set;

  always_comb begin
    // Edges come from the second and third stages, never the first
    base_edge = q.base_s2 && !q.base_s3;
    match_evt = q.match_s2 && !q.match_s3;
    next_cnt = q.cnt + 7'h01;
    mask = 7'(8'h7f >> q.period_select);
    tick_evt = base_edge && ((next_cnt & mask) == 7'h00);
    access = psel && penable && !q.pready;
    wr_done = psel && penable && q.pready && pwrite && !q.pslverr;
    hit = (paddr == `RTA_OFF_LEAP) || (paddr == `RTA_OFF_IRQ_EN) ||
          (paddr == `RTA_OFF_STATUS) || (paddr == `RTA_OFF_TICK_CFG);
    rd_val = 32'h0;
    unique case (paddr)
      `RTA_OFF_LEAP: rd_val[`RTA_BIT_LEAP] = q.leap_s2;
      `RTA_OFF_IRQ_EN: rd_val[1:0] = q.irq_en;
      `RTA_OFF_STATUS: rd_val[1:0] = q.status;
      `RTA_OFF_TICK_CFG: rd_val[3:0] = {q.wake_from_powerdown_enable, q.period_select};
      default: rd_val = 32'h0;
    endcase
    clr = 2'h0;
    if (wr_done && (paddr == `RTA_OFF_STATUS) && pstrb[0]) begin
      clr = pwdata[1:0];
    end
    set[`RTA_BIT_PERIODIC] = tick_evt && q.irq_en[`RTA_BIT_PERIODIC];
    // Alarm digits are compared upstream exactly as loaded, no range check
    set[`RTA_BIT_MATCH] = match_evt && q.irq_en[`RTA_BIT_MATCH];

    next_q = q;
    next_q.base_s1 = base_clk_pin;
    next_q.base_s2 = q.base_s1;
    next_q.base_s3 = q.base_s2;
    next_q.match_s1 = alarm_match_pin;
    next_q.match_s2 = q.match_s1;
    next_q.match_s3 = q.match_s2;
    next_q.leap_s1 = leap_year_flag;
    next_q.leap_s2 = q.leap_s1;
    next_q.pd_s1 = powerdown_pin;
    next_q.pd_s2 = q.pd_s1;
    if (base_edge) begin
      next_q.cnt = next_cnt;
    end
    // Set beats clear so an event in the clearing cycle survives
    next_q.status = (q.status & ~clr) | set;
    if (wr_done && pstrb[0]) begin
      if (paddr == `RTA_OFF_IRQ_EN) begin
        next_q.irq_en = pwdata[1:0];
      end
      if (paddr == `RTA_OFF_TICK_CFG) begin
        next_q.period_select = pwdata[`RTA_SEL_MSB:`RTA_SEL_LSB];
        next_q.wake_from_powerdown_enable = pwdata[`RTA_BIT_WAKE_EN];
      end
    end
    // One wait state: answer is registered, never combinational
    next_q.pready = access;
    next_q.pslverr = access && !hit;
    if (access) begin
      next_q.prdata = (pwrite || !hit) ? 32'h0 : rd_val;
    end
    next_q.irq = |(next_q.status & next_q.irq_en);
    next_q.wake_req = q.wake_from_powerdown_enable && q.pd_s2 &&
                      (tick_evt || match_evt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign wake_req = q.wake_req;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LEAP_READ: assert property (pready && psel && !pwrite && paddr == `RTA_OFF_LEAP |-> prdata == {31'h0, $past(q.leap_s2)}) else $error("Leap bit read wrong");
  AST_TICK_GATED: assert property (!q.status[1] && !(tick_evt && q.irq_en[1]) |=> !q.status[1]) else $error("Tick flag set while disabled");
  AST_MATCH_GATED: assert property (!q.status[0] && !(match_evt && q.irq_en[0]) |=> !q.status[0]) else $error("Alarm flag set while disabled");
  AST_TICK_SET: assert property (tick_evt && q.irq_en[1] |=> q.status[1]) else $error("Tick flag not set");
  AST_MATCH_SET: assert property (match_evt && q.irq_en[0] |=> q.status[0]) else $error("Alarm flag not set");
  AST_W1C: assert property (q.status[1] && !(wr_done && paddr == `RTA_OFF_STATUS && pstrb[0] && pwdata[1]) |=> q.status[1]) else $error("Flag dropped without clear");
  AST_W1C_CLEAR: assert property (wr_done && paddr == `RTA_OFF_STATUS && pstrb[0] && pwdata[0] && !set[0] |=> !q.status[0]) else $error("Flag not cleared");
  AST_WAKE: assert property (q.wake_from_powerdown_enable && q.pd_s2 && tick_evt |=> wake_req) else $error("No wake on tick");
  AST_PERIOD: assert property (tick_evt && q.period_select == 3'h0 |-> next_cnt == 7'h00) else $error("Tick period wrong");
  AST_STATUS_READ: assert property (pready && psel && !pwrite && paddr == `RTA_OFF_STATUS |-> prdata[1:0] == $past(q.status) && prdata[31:2] == 30'h0) else $error("Status read wrong");
  AST_IRQ: assert property (|(q.status & q.irq_en) |-> irq) else $error("Irq missing");
  AST_SYNC: assert property (match_evt |-> $past(alarm_match_pin, 2) && !$past(alarm_match_pin, 3)) else $error("Alarm edge not synchronised");

  COV_TICK: cover property (tick_evt && q.irq_en[1] ##1 irq);
  COV_MATCH: cover property (match_evt && q.irq_en[0] ##1 q.status[0]);
  COV_CLEAR_RACE: cover property (wr_done && clr[1] && set[1]);
  COV_WAKE: cover property (wake_req);

endmodule

`default_nettype wire

// File: sim/tb_rta_tick_alarm.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rtc_tick_alarm_irq;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, irq, wake_req;
  logic base = 0, alm = 0, leap = 0, pd = 0;
  int n_errors = 0, total_checks = 0, cyc = 0, n_wake = 0, w0;
  rta_tick_alarm dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .base_clk_pin(base), .alarm_match_pin(alm),
    .leap_year_flag(leap), .powerdown_pin(pd), .irq(irq), .wake_req(wake_req));
  initial forever #50 pclk = ~pclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tally_and_finish();
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Wake pulses last one cycle, so they are counted rather than sampled later
  always @(posedge pclk) begin
    cyc++;
    if (wake_req === 1'b1) n_wake++;
    if (cyc > 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    wt(16);
    presetn <= 1;
    apb(0, 12'h028, 0); chk(rd, 0);
    apb(0, 12'h02c, 0); chk(rd, 0);
    apb(0, 12'h030, 0); chk(rd, 0);
    apb(0, 12'h040, 0); chk({31'h0, err}, 1);
    leap <= 1;
    wt(4);
    apb(1, 12'h024, 0); apb(0, 12'h024, 0); chk(rd, 1);
    // Alarm while masked: no flag, but powerdown wake still fires
    apb(1, 12'h030, 32'h8);
    pd <= 1;
    alm <= 1;
    wt(6);
    alm <= 0;
    apb(0, 12'h02c, 0); chk(rd, 0);
    chk(n_wake, 1);
    apb(1, 12'h028, 32'h3); apb(0, 12'h028, 0); chk(rd, 3);
    alm <= 1;
    wt(6);
    chk({31'h0, irq}, 1);
    apb(0, 12'h02c, 0); chk(rd, 1);
    apb(1, 12'h02c, 0); apb(0, 12'h02c, 0); chk(rd, 1);
    apb(1, 12'h02c, 1); apb(0, 12'h02c, 0); chk(rd, 0);
    chk({31'h0, irq}, 0);
    // Period selects 3 to 7, each over 16 base edges; wake counts the ticks
    for (int s = 3; s < 8; s++) begin
      apb(1, 12'h030, 32'h8 | s); apb(0, 12'h030, 0); chk(rd, 32'h8 | s);
      w0 = n_wake;
      repeat (16) begin
        base <= 1;
        wt(3);
        base <= 0;
        wt(3);
      end
      chk(n_wake - w0, 16 >> (7 - s));
    end
    apb(0, 12'h02c, 0); chk(rd, 2);
    chk({31'h0, irq}, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
